// [rtl/ootc_regs.vh]
// ootc_regs.vh: register map, field positions, reset values, limits
// assumes 32-bit avalon-mm word addressing by byte offset
`ifndef OOTC_REGS_VH
`define OOTC_REGS_VH

`define OOTC_ADDR_CTRL      6'h00
`define OOTC_ADDR_SETPOINT  6'h04
`define OOTC_ADDR_HYS_HEAT  6'h08
`define OOTC_ADDR_HYS_COOL  6'h0c
`define OOTC_ADDR_DEAD_BAND 6'h10
`define OOTC_ADDR_FILTER    6'h14
`define OOTC_ADDR_STATUS    6'h18
`define OOTC_ADDR_AMBIENT   6'h1c

`define OOTC_CTRL_DIR       0
`define OOTC_CTRL_METHOD    1
`define OOTC_CTRL_HEATCOOL  2
`define OOTC_CTRL_FAHR      3
`define OOTC_CTRL_CH1_EN    4
`define OOTC_CTRL_RESTART   5

`define OOTC_ST_HEAT        0
`define OOTC_ST_COOL        1
`define OOTC_ST_AMB_ERR     2
`define OOTC_ST_METHOD      3
`define OOTC_ST_DIR         4

`define OOTC_RST_DIR        1'b0
`define OOTC_RST_METHOD     1'b1
`define OOTC_RST_HYS        16'sh000a
`define OOTC_RST_DEAD_BAND  16'sh0000
`define OOTC_RST_FILTER     16'h0000
`define OOTC_RST_SETPOINT   16'sh0000

`define OOTC_HYS_MIN        16'sh0001
`define OOTC_LIM_MAX        16'sh270f
`define OOTC_DB_MIN         -16'sh07cf
`define OOTC_AMB_MIN_C      -16'sh012c
`define OOTC_AMB_MAX_C      16'sh02ee
`define OOTC_AMB_MIN_F      16'sh0064
`define OOTC_AMB_MAX_F      16'sh06ae
`define OOTC_F_OFFSET       18'sh00140

`endif

// [rtl/ootc_ctrl.v]
// ootc_ctrl.v: on/off temperature control channel with avalon-mm settings
// assumes pv and cold junction readings are 0.1 C units, synchronous to clk_sys_i
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ootc_regs.vh"

module ootc_ctrl #(
    parameter DW = 16
) (
    // clock and reset
    input  wire                 clk_sys_i,
    input  wire                 rst_i,
    // avalon-mm slave
    input  wire [5:0]           avs_address_i,
    input  wire                 avs_read_i,
    input  wire                 avs_write_i,
    input  wire [31:0]          avs_writedata_i,
    input  wire [3:0]           avs_byteenable_i,
    output wire                 avs_waitrequest_o,
    output reg  [31:0]          avs_readdata_o,
    // measurement
    input  wire signed [DW-1:0] pv_i,
    input  wire signed [DW-1:0] cold_junction_sensor_i,
    // control outputs and filter setting
    output reg                  heat_out_o,
    output reg                  cool_out_o,
    output wire [DW-1:0]        filter_tc_o
);

////////////////////////////////////////////////////////////////////////////////
// bus handshake: one wait cycle, answer on second edge

reg                  ack_reg;
wire                 req;
wire                 wr_en;
wire                 all_lanes;

assign req               = avs_read_i | avs_write_i;
assign avs_waitrequest_o = req & ~ack_reg;
// write lands at the edge where waitrequest is sampled low
assign wr_en             = avs_write_i & ack_reg;
assign all_lanes         = avs_byteenable_i[1] & avs_byteenable_i[0];

always @(posedge clk_sys_i) begin
    if (rst_i) begin
        ack_reg <= 1'b0;
    end else begin
        ack_reg <= req & ~ack_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// settings

reg                  dir_pend_reg;
reg                  method_pend_reg;
reg                  dir_reg;
reg                  method_reg;
reg                  heatcool_reg;
reg                  fahr_reg;
reg                  ch1_en_reg;
reg signed [DW-1:0]  sp_reg;
reg signed [DW-1:0]  hys_heat_reg;
reg signed [DW-1:0]  hys_cool_reg;
reg signed [DW-1:0]  db_reg;
reg        [DW-1:0]  filter_reg;
wire signed [DW-1:0] wdat;
wire                 hys_ok;
wire                 db_ok;
wire                 filt_ok;

assign wdat    = avs_writedata_i[DW-1:0];
assign hys_ok  = (wdat >= `OOTC_HYS_MIN) && (wdat <= `OOTC_LIM_MAX);
assign db_ok   = (wdat >= `OOTC_DB_MIN) && (wdat <= `OOTC_LIM_MAX);
assign filt_ok = (wdat >= 16'sh0000) && (wdat <= `OOTC_LIM_MAX);

always @(posedge clk_sys_i) begin
    if (rst_i) begin
        dir_pend_reg    <= `OOTC_RST_DIR;
        method_pend_reg <= `OOTC_RST_METHOD;
        dir_reg         <= `OOTC_RST_DIR;
        method_reg      <= `OOTC_RST_METHOD;
        heatcool_reg    <= 1'b0;
        fahr_reg        <= 1'b0;
        ch1_en_reg      <= 1'b1;
        sp_reg          <= `OOTC_RST_SETPOINT;
        hys_heat_reg    <= `OOTC_RST_HYS;
        hys_cool_reg    <= `OOTC_RST_HYS;
        db_reg          <= `OOTC_RST_DEAD_BAND;
        filter_reg      <= `OOTC_RST_FILTER;
    end else if (wr_en && avs_byteenable_i[0]) begin
        case (avs_address_i)
            `OOTC_ADDR_CTRL: begin
                // method and direction wait for a restart
                dir_pend_reg    <= avs_writedata_i[`OOTC_CTRL_DIR];
                method_pend_reg <= avs_writedata_i[`OOTC_CTRL_METHOD];
                heatcool_reg    <= avs_writedata_i[`OOTC_CTRL_HEATCOOL];
                fahr_reg        <= avs_writedata_i[`OOTC_CTRL_FAHR];
                ch1_en_reg      <= avs_writedata_i[`OOTC_CTRL_CH1_EN];
                if (avs_writedata_i[`OOTC_CTRL_RESTART]) begin
                    dir_reg    <= avs_writedata_i[`OOTC_CTRL_DIR];
                    method_reg <= avs_writedata_i[`OOTC_CTRL_METHOD];
                end
            end
            `OOTC_ADDR_SETPOINT: begin
                if (all_lanes) begin
                    sp_reg <= wdat;
                end
            end
            `OOTC_ADDR_HYS_HEAT: begin
                if (all_lanes && hys_ok) begin
                    hys_heat_reg <= wdat;
                end
            end
            `OOTC_ADDR_HYS_COOL: begin
                if (all_lanes && hys_ok) begin
                    hys_cool_reg <= wdat;
                end
            end
            `OOTC_ADDR_DEAD_BAND: begin
                if (all_lanes && db_ok) begin
                    db_reg <= wdat;
                end
            end
            `OOTC_ADDR_FILTER: begin
                if (all_lanes && filt_ok) begin
                    filter_reg <= wdat;
                end
            end
            default: begin
                dir_pend_reg <= dir_pend_reg;
            end
        endcase
    end
end

assign filter_tc_o = filter_reg;

////////////////////////////////////////////////////////////////////////////////
// on/off control with hysteresis

wire signed [DW+1:0] err;
wire signed [DW+1:0] hh;
wire signed [DW+1:0] hc;
wire signed [DW+1:0] db;
reg                  heat_next;
reg                  cool_next;

assign err = {{2{pv_i[DW-1]}}, pv_i} - {{2{sp_reg[DW-1]}}, sp_reg};
assign hh  = {{2{hys_heat_reg[DW-1]}}, hys_heat_reg};
assign hc  = {{2{hys_cool_reg[DW-1]}}, hys_cool_reg};
assign db  = {{2{db_reg[DW-1]}}, db_reg};

always @* begin
    heat_next = heat_out_o;
    cool_next = cool_out_o;
    if (method_reg) begin
        // pid path lives elsewhere; on/off outputs held off
        heat_next = 1'b0;
        cool_next = 1'b0;
    end else begin
        // standard type uses heating hysteresis either way
        if (!dir_reg) begin
            if (err > 18'sh00000) begin
                heat_next = 1'b0;
            end else if (err <= -hh) begin
                heat_next = 1'b1;
            end
        end else begin
            if (err > 18'sh00000) begin
                heat_next = 1'b1;
            end else if (err <= -hh) begin
                heat_next = 1'b0;
            end
        end
        if (!heatcool_reg) begin
            cool_next = 1'b0;
        end else if (!dir_reg) begin
            // cooling waits beyond set point plus dead band
            if (err > db) begin
                cool_next = 1'b1;
            end else if (err <= db - hc) begin
                cool_next = 1'b0;
            end
        end else begin
            if (err < -db) begin
                cool_next = 1'b1;
            end else if (err >= hc - db) begin
                cool_next = 1'b0;
            end
        end
    end
end

always @(posedge clk_sys_i) begin
    if (rst_i) begin
        heat_out_o <= 1'b0;
        cool_out_o <= 1'b0;
    end else begin
        heat_out_o <= heat_next;
        cool_out_o <= cool_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// terminal ambient temperature

reg signed [DW-1:0]  amb_reg;
reg                  amb_err_reg;
wire signed [DW+3:0] cj_ext;
wire signed [DW+3:0] cj_f;
wire signed [DW-1:0] amb_next;
wire                 amb_err_next;

// four guard bits keep the times-nine product from wrapping
assign cj_ext = {{4{cold_junction_sensor_i[DW-1]}}, cold_junction_sensor_i};
assign cj_f   = (cj_ext * 20'sh00009) / 20'sh00005 + `OOTC_F_OFFSET;

// channel one unit applies even with channel one disabled
assign amb_next = fahr_reg ? cj_f[DW-1:0] : cold_junction_sensor_i;

assign amb_err_next = fahr_reg ?
    ((cj_f < `OOTC_AMB_MIN_F) || (cj_f > `OOTC_AMB_MAX_F)) :
    ((amb_next < `OOTC_AMB_MIN_C) || (amb_next > `OOTC_AMB_MAX_C));

always @(posedge clk_sys_i) begin
    if (rst_i) begin
        amb_reg     <= {DW{1'b0}};
        amb_err_reg <= 1'b0;
    end else begin
        amb_reg     <= amb_next;
        amb_err_reg <= amb_err_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read path

reg [31:0] rd_mux;

always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address_i)
        `OOTC_ADDR_CTRL: begin
            rd_mux[`OOTC_CTRL_DIR]      = dir_pend_reg;
            rd_mux[`OOTC_CTRL_METHOD]   = method_pend_reg;
            rd_mux[`OOTC_CTRL_HEATCOOL] = heatcool_reg;
            rd_mux[`OOTC_CTRL_FAHR]     = fahr_reg;
            rd_mux[`OOTC_CTRL_CH1_EN]   = ch1_en_reg;
        end
        `OOTC_ADDR_SETPOINT: begin
            rd_mux = {{(32-DW){sp_reg[DW-1]}}, sp_reg};
        end
        `OOTC_ADDR_HYS_HEAT: begin
            rd_mux = {{(32-DW){1'b0}}, hys_heat_reg};
        end
        `OOTC_ADDR_HYS_COOL: begin
            rd_mux = {{(32-DW){1'b0}}, hys_cool_reg};
        end
        `OOTC_ADDR_DEAD_BAND: begin
            rd_mux = {{(32-DW){db_reg[DW-1]}}, db_reg};
        end
        `OOTC_ADDR_FILTER: begin
            rd_mux = {{(32-DW){1'b0}}, filter_reg};
        end
        `OOTC_ADDR_STATUS: begin
            rd_mux[`OOTC_ST_HEAT]    = heat_out_o;
            rd_mux[`OOTC_ST_COOL]    = cool_out_o & heatcool_reg;
            rd_mux[`OOTC_ST_AMB_ERR] = amb_err_reg;
            rd_mux[`OOTC_ST_METHOD]  = method_reg;
            rd_mux[`OOTC_ST_DIR]     = dir_reg;
        end
        `OOTC_ADDR_AMBIENT: begin
            rd_mux = {{(32-DW){amb_reg[DW-1]}}, amb_reg};
        end
        default: begin
            rd_mux = 32'h0000_0000;
        end
    endcase
end

always @(posedge clk_sys_i) begin
    if (rst_i) begin
        avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_reg) begin
        avs_readdata_o <= rd_mux;
    end
end

endmodule
`default_nettype wire

// [test/ootc_ctrl_assertions.sv]
// ootc_ctrl_assertions.sv: port checks of the on/off control loop
// assumes bind onto ootc_ctrl; settings are shadowed from bus writes
`timescale 1ns/100ps
`default_nettype none
`include "ootc_regs.vh"
module ootc_chk (
    // clock and reset
    input wire logic               clk_sys_i,
    input wire logic               rst_i,
    // register bus
    input wire logic [5:0]         avs_address_i,
    input wire logic               avs_write_i,
    input wire logic [31:0]        avs_writedata_i,
    input wire logic [3:0]         avs_byteenable_i,
    input wire logic               avs_waitrequest_o,
    // control
    input wire logic signed [15:0] pv_i,
    input wire logic               heat_out_o,
    input wire logic               cool_out_o,
    input wire logic [15:0]        filter_tc_o
);
    logic signed [15:0] sp;
    logic signed [15:0] hh;
    logic               meth;
    logic               dir;
    logic               hc;
    wire                wr = avs_write_i && !avs_waitrequest_o;
    wire                w16 = wr && avs_byteenable_i[1:0] == 2'h3;
    wire signed [15:0]  wd = avs_writedata_i[15:0];
    wire signed [16:0]  e = pv_i - sp;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sp <= 16'sh0000;
            hh <= 16'sh000a;
            meth <= 1'b1;
            dir <= 1'b0;
            hc <= 1'b0;
        end else begin
            if (w16 && avs_address_i == `OOTC_ADDR_SETPOINT)
                sp <= wd;
            if (w16 && avs_address_i == `OOTC_ADDR_HYS_HEAT && wd >= 1 && wd <= 9999)
                hh <= wd;
            if (wr && avs_byteenable_i[0] && avs_address_i == `OOTC_ADDR_CTRL) begin
                hc <= avs_writedata_i[2];
                if (avs_writedata_i[5]) begin
                    dir <= avs_writedata_i[0];
                    meth <= avs_writedata_i[1];
                end
            end
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_rev; !meth && !dir; endsequence
    sequence s_dir; !meth && dir; endsequence
    sequence s_filt; w16 && avs_address_i == `OOTC_ADDR_FILTER && wd >= 0 && wd <= 9999; endsequence
    a_rev_heat_off: assert property (s_rev and e > 0 |=> !heat_out_o)
        else $error("heat on above set point");
    a_rev_heat_on: assert property (s_rev and e <= -hh |=> heat_out_o)
        else $error("heat off below hysteresis");
    a_rev_heat_hold: assert property (s_rev and e <= 0 && e > -hh |=> $stable(heat_out_o))
        else $error("heat changed inside hysteresis");
    a_dir_heat_on: assert property (s_dir and e > 0 |=> heat_out_o)
        else $error("direct heat off above set point");
    a_dir_heat_off: assert property (s_dir and e <= -hh |=> !heat_out_o)
        else $error("direct heat on below hysteresis");
    a_pid_idle: assert property (meth |=> !heat_out_o && !cool_out_o)
        else $error("output active under pid");
    a_std_no_cool: assert property (!hc |=> !cool_out_o)
        else $error("cool on in standard type");
    a_filter_now: assert property (s_filt |=> filter_tc_o == $past(wd))
        else $error("filter constant not applied");
endmodule
bind ootc_ctrl ootc_chk u_ootc_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_waitrequest_o(avs_waitrequest_o), .pv_i(pv_i), .heat_out_o(heat_out_o),
    .cool_out_o(cool_out_o), .filter_tc_o(filter_tc_o));
`default_nettype wire

// [test/ootc_host.sv]
// ootc_host.sv: host model, one avalon-mm access per go pulse
// assumes slave answers by dropping waitrequest
`timescale 1ns/100ps
`default_nettype none
module ootc_host (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // command
    input  wire logic        go_i,
    input  wire logic        wr_i,
    input  wire logic [5:0]  addr_i,
    input  wire logic [31:0] data_i,
    output var  logic        done_o,
    output var  logic [31:0] rdata_o,
    // avalon-mm master
    output var  logic        avs_read_o,
    output var  logic        avs_write_o,
    output var  logic [5:0]  avs_address_o,
    output var  logic [31:0] avs_writedata_o,
    output var  logic [3:0]  avs_byteenable_o,
    input  wire logic        avs_waitrequest_i,
    input  wire logic [31:0] avs_readdata_i
);
    initial {avs_read_o, avs_write_o, avs_address_o, avs_writedata_o, done_o} = '0;
    initial avs_byteenable_o = 4'hf;
    always @(posedge clk_sys_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            avs_read_o <= 1'b0;
            avs_write_o <= 1'b0;
        end else if ((avs_read_o || avs_write_o) && !avs_waitrequest_i) begin
            avs_read_o <= 1'b0;
            avs_write_o <= 1'b0;
            // released data no longer shows the last value
            avs_writedata_o <= ~avs_writedata_o;
            rdata_o <= avs_readdata_i;
            done_o <= 1'b1;
        end else if (go_i) begin
            avs_read_o <= !wr_i;
            avs_write_o <= wr_i;
            avs_address_o <= addr_i;
            avs_writedata_o <= data_i;
        end
    end
endmodule
`default_nettype wire

// [test/tb_onoff_temperature_control.sv]
// tb_onoff_temperature_control.sv: self-checking bench of ootc_ctrl
// assumes ootc_host as bus master and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "ootc_regs.vh"
module tb_onoff_temperature_control;
    logic clk_sys_i, rst_i, go, wr;
    logic [5:0] addr;
    logic [31:0] wdat;
    logic signed [15:0] pv, cj;
    wire done, rd_w, wr_w, wt, heat, cool;
    wire [5:0] a_w;
    wire [31:0] wd_w, rd_d, rdat;
    wire [3:0] be_w;
    wire [15:0] ftc;
    int error_cnt = 0;
    int checked = 0;
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    ootc_ctrl u_ootc_ctrl (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(a_w),
        .avs_read_i(rd_w), .avs_write_i(wr_w), .avs_writedata_i(wd_w),
        .avs_byteenable_i(be_w), .avs_waitrequest_o(wt), .avs_readdata_o(rd_d),
        .pv_i(pv), .cold_junction_sensor_i(cj), .heat_out_o(heat),
        .cool_out_o(cool), .filter_tc_o(ftc));
    ootc_host u_ootc_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .go_i(go), .wr_i(wr),
        .addr_i(addr), .data_i(wdat), .done_o(done), .rdata_o(rdat),
        .avs_read_o(rd_w), .avs_write_o(wr_w), .avs_address_o(a_w),
        .avs_writedata_o(wd_w), .avs_byteenable_o(be_w),
        .avs_waitrequest_i(wt), .avs_readdata_i(rd_d));
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask
    task end_sim;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        go <= 1'b1;
        wr <= w;
        addr <= a;
        wdat <= d;
        @(posedge clk_sys_i);
        go <= 1'b0;
        repeat (20) begin
            @(posedge clk_sys_i);
            if (done === 1'b1) break;
        end
    endtask
    task rdc(input logic [5:0] a, input logic [31:0] x);
        xfer(1'b0, a, 32'h0);
        chk("readdata", rdat, x);
    endtask
    task pvx(input logic signed [15:0] v, input logic h, input logic c);
        pv <= v;
        repeat (2) @(posedge clk_sys_i);
        chk("heat", 32'(heat), 32'(h));
        chk("cool", 32'(cool), 32'(c));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        rdc(`OOTC_ADDR_HYS_HEAT, 32'h0000000a);
        rdc(`OOTC_ADDR_HYS_COOL, 32'h0000000a);
        rdc(`OOTC_ADDR_DEAD_BAND, 32'h00000000);
        rdc(`OOTC_ADDR_STATUS, 32'h00000008);
        rdc(6'h20, 32'h00000000);
    endtask
    task t_rev;
        xfer(1'b1, `OOTC_ADDR_CTRL, 32'h00000030);
        xfer(1'b1, `OOTC_ADDR_SETPOINT, 32'h000003e8);
        pvx(16'sh03e9, 1'b0, 1'b0);
        pvx(16'sh03e3, 1'b0, 1'b0);
        pvx(16'sh03de, 1'b1, 1'b0);
        pvx(16'sh03e8, 1'b1, 1'b0);
        pvx(16'sh03e9, 1'b0, 1'b0);
        xfer(1'b1, `OOTC_ADDR_HYS_HEAT, 32'h00000000);
        rdc(`OOTC_ADDR_HYS_HEAT, 32'h0000000a);
        xfer(1'b1, `OOTC_ADDR_HYS_HEAT, 32'h00000014);
        xfer(1'b1, `OOTC_ADDR_HYS_HEAT, 32'h00002710);
        rdc(`OOTC_ADDR_HYS_HEAT, 32'h00000014);
        pvx(16'sh03d9, 1'b0, 1'b0);
        pvx(16'sh03d4, 1'b1, 1'b0);
    endtask
    task t_dir;
        xfer(1'b1, `OOTC_ADDR_CTRL, 32'h00000011);
        rdc(`OOTC_ADDR_STATUS, 32'h00000001);
        xfer(1'b1, `OOTC_ADDR_CTRL, 32'h00000031);
        pvx(16'sh03e9, 1'b1, 1'b0);
        pvx(16'sh03de, 1'b1, 1'b0);
        pvx(16'sh03d4, 1'b0, 1'b0);
        rdc(`OOTC_ADDR_STATUS, 32'h00000010);
    endtask
    task t_cool;
        xfer(1'b1, `OOTC_ADDR_CTRL, 32'h00000034);
        pvx(16'sh03e9, 1'b0, 1'b1);
        pvx(16'sh03e3, 1'b0, 1'b1);
        pvx(16'sh03de, 1'b0, 1'b0);
        xfer(1'b1, `OOTC_ADDR_DEAD_BAND, 32'h00000032);
        pvx(16'sh0406, 1'b0, 1'b0);
        pvx(16'sh0424, 1'b0, 1'b1);
        rdc(`OOTC_ADDR_STATUS, 32'h00000002);
    endtask
    task t_amb;
        rdc(`OOTC_ADDR_AMBIENT, 32'h000000fa);
        cj <= -16'sh012d;
        rdc(`OOTC_ADDR_STATUS, 32'h00000006);
        cj <= 16'sh02ee;
        rdc(`OOTC_ADDR_STATUS, 32'h00000002);
        cj <= 16'sh02ef;
        rdc(`OOTC_ADDR_STATUS, 32'h00000006);
        cj <= 16'sh00fa;
        xfer(1'b1, `OOTC_ADDR_CTRL, 32'h0000000c);
        rdc(`OOTC_ADDR_AMBIENT, 32'h00000302);
    endtask
    task t_filt;
        xfer(1'b1, `OOTC_ADDR_FILTER, 32'h000004d2);
        chk("filter", 32'(ftc), 32'h000004d2);
        xfer(1'b1, `OOTC_ADDR_FILTER, 32'h00002710);
        chk("filter", 32'(ftc), 32'h000004d2);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_i, go, wr, addr, wdat, pv} = {1'b1, 1'b0, 1'b0, 6'h0, 32'h0, 16'sh0};
        cj = 16'sh00fa;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset;
        t_rev;
        t_dir;
        t_cool;
        t_amb;
        t_filt;
        end_sim;
    end
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        error_cnt++;
        end_sim;
    end
endmodule
`default_nettype wire
